// *** sam_col_mux.sv ***
`timescale 1ns/1ps
module sam_col_mux
    import sam_pkg::*;
(
    input  wire logic [SAM_IAW-1:0] internal_address_bit,
    input  wire sam_cfg_t           cfg,
    input  wire logic               byte_mode,
    output logic      [SAM_MDW-1:0] col_word
);

    logic [SAM_IAW-1:0] ia;
    logic [7:1]         col_low;
    assign ia = internal_address_bit;

    // Kept apart from col_word so that no vector mixes driver kinds
    genvar g;
    generate
        for (g = 1; g < 8; g++)
        begin : g_low
            assign col_low[g] = ia[g+1];
        end
    endgenerate

    always_comb
    begin
        col_word[7:1] = col_low;
        col_word[0]  = ia[1];
        col_word[8]  = ia[9];
        col_word[9]  = ia[10];
        col_word[10] = 1'b0;
        col_word[11] = ia[12];
        col_word[12] = ia[13];
        if (cfg.sdram_enable_bit)
        begin
            // Byte lanes always need bit 0 on the lowest line
            col_word[0]  = (cfg.col0_source_select || byte_mode) ?
                           ia[0] : ia[1];
            col_word[8]  = cfg.col_line8_source_select ?
                           ia[1] : ia[9];
            col_word[9]  = cfg.col_line9_source_select ?
                           ia[1] : ia[10];
            col_word[10] = 1'b0;
            col_word[11] = sam_line11(ia, cfg.line11_source_select);
            col_word[12] = sam_line12(ia, cfg.line12_source_field);
        end
        else
        begin
            col_word[8]  = cfg.col_line8_source_select ? ia[0] : ia[9];
            col_word[10] = ia[11];
        end
        // Upper bank lines hold in both phases
        col_word[13] = ia[22];
        col_word[14] = ia[23];
        col_word[15] = ia[24];
    end

endmodule : sam_col_mux

// *** sam_pkg.sv ***
package sam_pkg;

    localparam int unsigned SAM_IAW = 25;   // Internal address bits 24..0
    localparam int unsigned SAM_MDW = 16;   // Muxed address lines 15..0
    localparam int unsigned SAM_DW  = 16;   // Register data width
    localparam int unsigned SAM_RAW = 2;    // Register address width

    // Register indices on the plain register port
    localparam logic [SAM_RAW-1:0] SAM_MEMCFG_OFS = 2'h0;
    localparam logic [SAM_RAW-1:0] SAM_SDCTL_OFS  = 2'h1;
    localparam logic [SAM_RAW-1:0] SAM_MDOUT_OFS  = 2'h2;

    localparam logic [SAM_DW-1:0] SAM_MEMCFG_RST = 16'h0000;
    localparam logic [SAM_DW-1:0] SAM_SDCTL_RST  = 16'h0000;

    // memory_configuration_register fields
    localparam int unsigned SAM_ROWWIDE_BIT = 0;
    localparam int unsigned SAM_COL9_BIT    = 1;
    localparam int unsigned SAM_COL_LINE8_SOURCE_SELECT_BIT    = 5;
    localparam int unsigned SAM_L11_BIT     = 11;
    localparam int unsigned SAM_L12_LO      = 14;
    localparam int unsigned SAM_L12_HI      = 15;
    // SDRAM control register fields
    localparam int unsigned SAM_COL0_BIT    = 6;
    localparam int unsigned SAM_SDRAM_ENABLE_BIT_BIT    = 15;

    localparam logic [SAM_DW-1:0] SAM_MEMCFG_WMASK = 16'hc823;
    localparam logic [SAM_DW-1:0] SAM_SDCTL_WMASK  = 16'h8040;

    // line12_source_field codes
    localparam logic [1:0] SAM_L12_IA10 = 2'h0;
    localparam logic [1:0] SAM_L12_IA21 = 2'h1;
    localparam logic [1:0] SAM_L12_IA23 = 2'h2;

    typedef struct packed {
        logic       sdram_enable_bit;
        logic       col0_source_select;
        logic       col_line8_source_select;
        logic       col_line9_source_select;
        logic       row_wide_select;
        logic       line11_source_select;
        logic [1:0] line12_source_field;
    } sam_cfg_t;

    // Line 11 source, shared by the row phase and the SDRAM column phase
    function automatic logic sam_line11(input logic [SAM_IAW-1:0] ia,
                                        input logic sel);
        sam_line11 = sel ? ia[22] : ia[20];
    endfunction : sam_line11

    // Line 12 source; the spare code falls back to bit 10
    function automatic logic sam_line12(input logic [SAM_IAW-1:0] ia,
                                        input logic [1:0] fld);
        unique case (fld)
            SAM_L12_IA21: sam_line12 = ia[21];
            SAM_L12_IA23: sam_line12 = ia[23];
            default:      sam_line12 = ia[10];
        endcase
    endfunction : sam_line12

endpackage : sam_pkg

// *** sam_sdram_model.sv ***
`timescale 1ns/1ps
module sam_sdram_model
    import sam_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               row_phase,
    input  wire logic [SAM_MDW-1:0] muxed_dram_address_line,
    output logic      [SAM_MDW-1:0] row_word,
    output logic      [SAM_MDW-1:0] col_word
);
    logic phase_r;
    // The mux output lags its phase input by one cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_r  <= 1'b0;
            row_word <= 16'h0000;
            col_word <= 16'h0000;
        end
        else
        begin
            phase_r <= row_phase;
            if (phase_r)
                row_word <= muxed_dram_address_line;
            else
                col_word <= muxed_dram_address_line;
        end
    end
endmodule : sam_sdram_model

// *** sam_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - In SDRAM mode, column line 0 carries bit 1 when its select is 0, bit 0 when 1.
// - Column line 8 carries bit 9 when its select is 0 and bit 1 (bit 0 outside SDRAM mode) when it is 1.
// - Line 11 carries bit 20 when its select is 0 and bit 22 when it is 1.
// - Line 12 carries bit 10, 21 or 23 for field codes 00, 01 and 10.
// - SDRAM column choices apply only while the SDRAM enable bit is 1, except the line 8 select, which then picks bit 0 instead of bit 1.
// - The 16 Mbit map puts bits 11-18, 10, 9, 19, 20 on rows, 1-8 and 0 on columns.
// - In 8-bit column phase with SDRAM mode on, line 0 carries bit 0 and bit 1 moves to line 8 or 9; outside SDRAM mode 8-bit phase changes nothing.
// - The 64 Mbit map adds bank lines 12 and 13 carrying bits 21 and 22.
// - The 128 Mbit map puts bits 20, 19, 21, 10 on rows 8-10 and 12, banks 22, 23.
// - The 256 Mbit map adds bank lines 14 and 15 carrying bits 23 and 24.
module sam_top
    import sam_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic [SAM_RAW-1:0] reg_addr,
    input  wire logic [SAM_DW-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [SAM_DW-1:0]  reg_rdata,
    input  wire logic [SAM_IAW-1:0] internal_address_bit,
    input  wire logic               row_phase,
    input  wire logic               byte_mode,
    output logic      [SAM_MDW-1:0] muxed_dram_address_line
);

    logic [SAM_DW-1:0]  memcfg_r;
    logic [SAM_DW-1:0]  sdctl_r;
    logic [SAM_DW-1:0]  rdata_nxt;
    logic [SAM_MDW-1:0] row_word;
    logic [7:1]         row_low;
    logic [SAM_MDW-1:0] col_word;
    logic [SAM_MDW-1:0] md_nxt;
    logic [SAM_MDW-1:0] md_r;
    logic [SAM_DW-1:0]  rdata_r;
    logic [SAM_IAW-1:0] ia;
    sam_cfg_t           cfg;

    assign ia = internal_address_bit;

    // Register writes; only defined bits hold state
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            memcfg_r <= SAM_MEMCFG_RST;
            sdctl_r  <= SAM_SDCTL_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == SAM_MEMCFG_OFS)
                memcfg_r <= reg_wdata & SAM_MEMCFG_WMASK;
            if (reg_addr == SAM_SDCTL_OFS)
                sdctl_r <= reg_wdata & SAM_SDCTL_WMASK;
        end
    end

    always_comb
    begin
        cfg.sdram_enable_bit        = sdctl_r[SAM_SDRAM_ENABLE_BIT_BIT];
        cfg.col0_source_select      = sdctl_r[SAM_COL0_BIT];
        cfg.col_line8_source_select = memcfg_r[SAM_COL_LINE8_SOURCE_SELECT_BIT];
        cfg.col_line9_source_select = memcfg_r[SAM_COL9_BIT];
        cfg.row_wide_select         = memcfg_r[SAM_ROWWIDE_BIT];
        cfg.line11_source_select    = memcfg_r[SAM_L11_BIT];
        cfg.line12_source_field     = memcfg_r[SAM_L12_HI:SAM_L12_LO];
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_comb
    begin
        rdata_nxt = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                SAM_MEMCFG_OFS: rdata_nxt = memcfg_r;
                SAM_SDCTL_OFS:  rdata_nxt = sdctl_r;
                SAM_MDOUT_OFS:  rdata_nxt = md_r;
                default:        rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    // Row phase
    genvar g;
    generate
        for (g = 1; g < 8; g++)
        begin : g_row
            assign row_low[g] = ia[g+11];
        end
    endgenerate

    always_comb
    begin
        row_word[7:1] = row_low;
        row_word[0]  = ia[11];
        // Wide row map swaps in the upper bits for large parts
        row_word[8]  = cfg.row_wide_select ? ia[20] : ia[10];
        row_word[9]  = cfg.row_wide_select ? ia[19] : ia[9];
        row_word[10] = cfg.row_wide_select ? ia[21] : ia[19];
        row_word[11] = sam_line11(ia, cfg.line11_source_select);
        row_word[12] = sam_line12(ia, cfg.line12_source_field);
        row_word[13] = ia[22];
        row_word[14] = ia[23];
        row_word[15] = ia[24];
    end

    sam_col_mux u_col (
        .internal_address_bit (ia),
        .cfg                  (cfg),
        .byte_mode            (byte_mode),
        .col_word             (col_word)
    );

    assign md_nxt = row_phase ? row_word : col_word;

    // Registered pins keep the mux glitch out of the memory
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            md_r <= '0;
        else
            md_r <= md_nxt;
    end

    assign muxed_dram_address_line = md_r;
    assign reg_rdata               = rdata_r;

    // Checks
    sequence s_sd_col;
        !row_phase && cfg.sdram_enable_bit;
    endsequence

    a_col0_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_sd_col and !byte_mode |=>
        md_r[0] == ($past(cfg.col0_source_select) ? $past(ia[0])
                                                  : $past(ia[1])))
        else $error("Column line 0 source wrong");

    a_col_line8_source_select_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_sd_col |=>
        md_r[8] == ($past(cfg.col_line8_source_select) ? $past(ia[1])
                                                       : $past(ia[9])))
        else $error("Column line 8 source wrong");

    a_line11_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (row_phase || cfg.sdram_enable_bit) |=>
        md_r[11] == ($past(cfg.line11_source_select) ? $past(ia[22])
                                                     : $past(ia[20])))
        else $error("Line 11 source wrong");

    a_line12_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (row_phase || cfg.sdram_enable_bit)
        && cfg.line12_source_field == SAM_L12_IA23 |=> md_r[12] == $past(ia[23]))
        else $error("Line 12 code 10 not routing bit 23");

    a_line12_spare: assert property (@(posedge ref_clk) disable iff (!rst_n)
        row_phase && cfg.line12_source_field == 2'h3
        |=> md_r[12] == $past(ia[10]))
        else $error("Spare line 12 code not routing bit 10");

    a_edo_column: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !row_phase && !cfg.sdram_enable_bit |=> md_r[10] == $past(ia[11]))
        else $error("Non-SDRAM column line 10 wrong");

    a_row_low_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        row_phase |=> md_r[7:0] == $past(ia[18:11]))
        else $error("Row lines 0-7 wrong");

    a_byte_col0: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_sd_col and byte_mode |=> md_r[0] == $past(ia[0]) && md_r[10] == 1'b0)
        else $error("8-bit column map wrong");

    a_bank_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> md_r[15:13] == $past(ia[24:22]))
        else $error("Bank lines not held");

    a_wide_row: assert property (@(posedge ref_clk) disable iff (!rst_n)
        row_phase && cfg.row_wide_select ##1 1'b1 |->
        md_r[10:8] == {$past(ia[21]), $past(ia[19]), $past(ia[20])})
        else $error("Wide row map wrong");

endmodule : sam_top

// *** tb.sv ***
`timescale 1ns/1ps
module tb
    import sam_pkg::*;
;
    logic               ref_clk, rst_n, reg_wr, reg_rd, row_phase, byte_mode;
    logic [SAM_RAW-1:0] reg_addr;
    logic [SAM_DW-1:0]  reg_wdata, reg_rdata, rd_val, memcfg_sh, sdctl_sh;
    logic [SAM_IAW-1:0] ia;
    logic [SAM_MDW-1:0] md, row_word, col_word;
    int                 err_count, total_checks;

    sam_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .internal_address_bit(ia),
        .row_phase(row_phase), .byte_mode(byte_mode),
        .muxed_dram_address_line(md));
    sam_sdram_model i_mem (.ref_clk(ref_clk), .rst_n(rst_n),
        .row_phase(row_phase), .muxed_dram_address_line(md),
        .row_word(row_word), .col_word(col_word));

    function automatic logic [SAM_MDW-1:0] exp_md(
        input logic [SAM_IAW-1:0] a, input logic row, input logic byt);
        logic [SAM_MDW-1:0] e;
        logic w, l11v, l12v;
        w = memcfg_sh[0];
        l11v = memcfg_sh[11] ? a[22] : a[20];
        l12v = memcfg_sh[15:14] == 2'h1 ? a[21] :
               memcfg_sh[15:14] == 2'h2 ? a[23] : a[10];
        e[15:13] = a[24:22];
        if (row)
            e[12:0] = {l12v, l11v, w ? a[21] : a[19], w ? a[19] : a[9],
                       w ? a[20] : a[10], a[18:11]};
        else if (sdctl_sh[15])
            e[12:0] = {l12v, l11v, 1'b0, memcfg_sh[1] ? a[1] : a[10],
                       memcfg_sh[5] ? a[1] : a[9], a[8:2],
                       (sdctl_sh[6] | byt) ? a[0] : a[1]};
        else
            e[12:0] = {a[13:10], memcfg_sh[5] ? a[0] : a[9], a[8:1]};
        return e;
    endfunction : exp_md

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : cmp

    task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        if (a == 2'h0) memcfg_sh = d & 16'hc823;
        if (a == 2'h1) sdctl_sh = d & 16'h8040;
    endtask : reg_write

    task automatic reg_read(input logic [1:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        cmp(reg_rdata, exp);
    endtask : reg_read

    // Walking one shows every line's source bit on its own
    task automatic sweep(input logic row, input logic byt);
        for (int i = 0; i < SAM_IAW; i++)
        begin
            @(posedge ref_clk);
            ia        <= 25'h0000001 << i;
            row_phase <= row;
            byte_mode <= byt;
            @(posedge ref_clk);
            #1;
            cmp(md, exp_md(25'h0000001 << i, row, byt));
        end
    endtask : sweep

    task automatic t_regs;
        reg_read(2'h0, 16'h0000);
        reg_read(2'h1, 16'h0000);
        reg_write(2'h0, 16'hffff);
        reg_write(2'h1, 16'hffff);
        reg_write(2'h3, 16'hffff);
        reg_read(2'h0, 16'hc823);
        reg_read(2'h1, 16'h8040);
        reg_read(2'h3, 16'h0000);
        // All-ones address makes the readback of the pins non-trivial
        @(posedge ref_clk);
        ia        <= 25'h1ff_ffff;
        row_phase <= 1'b1;
        reg_read(2'h2, 16'hffff);
    endtask : t_regs

    task automatic t_col;
        logic [15:0] sd [4] = '{16'h8000, 16'h8040, 16'h0040, 16'h0000};
        for (int s = 0; s < 4; s++)
            for (int c = 0; c < 2; c++)
            begin
                reg_write(2'h1, sd[s]);
                reg_write(2'h0, c ? 16'h0022 : 16'h0000);
                sweep(1'b0, 1'b0);
                sweep(1'b0, 1'b1);
            end
    endtask : t_col

    task automatic t_lines;
        reg_write(2'h1, 16'h8000);
        for (int code = 0; code < 4; code++)
            for (int l = 0; l < 2; l++)
            begin
                reg_write(2'h0, {code[1:0], 2'h0, l[0], 11'h000});
                sweep(1'b1, 1'b0);
                sweep(1'b0, 1'b0);
            end
    endtask : t_lines

    task automatic t_maps;
        logic [SAM_IAW-1:0] pat;
        reg_write(2'h1, 16'h8000);
        for (int m = 0; m < 4; m++)
        begin
            pat = m[0] ? 25'h0e5_3c96 : 25'h11a_c369;
            reg_write(2'h0, m[1] ? 16'h0001 : 16'h0000);
            @(posedge ref_clk);
            ia        <= pat;
            row_phase <= 1'b1;
            byte_mode <= 1'b0;
            repeat (3) @(posedge ref_clk);
            #1;
            cmp(row_word, exp_md(pat, 1'b1, 1'b0));
            @(posedge ref_clk);
            row_phase <= 1'b0;
            repeat (3) @(posedge ref_clk);
            #1;
            cmp(col_word, exp_md(pat, 1'b0, 1'b0));
        end
    endtask : t_maps

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial
    begin
        rst_n = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ia = 25'h0000000;
        row_phase = 1'b0;
        byte_mode = 1'b0;
        memcfg_sh = 16'h0000;
        sdctl_sh = 16'h0000;
        err_count = 0;
        total_checks = 0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs;
        t_col;
        t_lines;
        t_maps;
        close_out;
    end

    // Guards against a hang anywhere in the sequence
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        close_out;
    end
endmodule : tb
